// >>> pkg/fbg_pkg.sv
package fbg_pkg;
    // reference rate and system clock, in Hz
    localparam int REF_HZ   = 48000000;
    localparam int CLK_HZ   = 250000000;
    // reference enable comes from a phase accumulator stepping in MHz units
    localparam int REF_STEP = REF_HZ / 1000000;
    localparam int REF_MOD  = CLK_HZ / 1000000;
    localparam int ACC_W    = 9;

    localparam int DIV_W    = 19;
    localparam int MASK_W   = 16;
    localparam int DATA_W   = 8;
    localparam int ADDR_W   = 8;
    localparam int POS_W    = 4;
    localparam int DIV_HI_W = 3;

    // register offsets
    localparam logic [7:0] OFS_DIV_LOW  = 8'h04;
    localparam logic [7:0] OFS_DIV_MID  = 8'h05;
    localparam logic [7:0] OFS_DIV_HIGH = 8'h06;
    localparam logic [7:0] OFS_TXM_LOW  = 8'h07;
    localparam logic [7:0] OFS_TXM_HIGH = 8'h08;
    localparam logic [7:0] OFS_RXM_LOW  = 8'h09;
    localparam logic [7:0] OFS_RXM_HIGH = 8'h0a;
    localparam logic [7:0] OFS_STATUS   = 8'h20;

    // status field positions
    localparam int ST_TX_RUN  = 0;
    localparam int ST_RX_RUN  = 1;
    localparam int ST_TX_PEND = 2;
    localparam int ST_RX_PEND = 3;
    localparam int ST_POS_LSB = 4;

    // reset values
    localparam logic [18:0] DIV_RESET  = 19'h00000;
    localparam logic [15:0] MASK_RESET = 16'h0000;
endpackage

// >>> hw/fbg_bit_timer.sv
`timescale 1ns/10ps
module fbg_bit_timer #(
    parameter int DIV_W  = fbg_pkg::DIV_W,
    parameter int MASK_W = fbg_pkg::MASK_W,
    parameter int POS_W  = fbg_pkg::POS_W
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // timing control
    input  wire logic              ref_tick,
    input  wire logic              enable,
    input  wire logic              char_start,
    input  wire logic [DIV_W-1:0]  divisor,
    input  wire logic [MASK_W-1:0] mask,
    // results
    output logic                   bit_tick,
    output logic                   running,
    output logic [POS_W-1:0]       bit_pos
);
    typedef struct packed {
        logic              running;
        logic [POS_W-1:0]  pos;
        logic [DIV_W:0]    cnt;
        logic [DIV_W-1:0]  div;
        logic [MASK_W-1:0] mask;
        logic              tick;
    } fbg_timer_state_t;

    fbg_timer_state_t st;
    fbg_timer_state_t next_st;

    // a zero length (divisor zero, mask bit clear) is set to one, ending a bit every reference tick
    function automatic logic [DIV_W:0] fbg_bit_len(input logic [DIV_W-1:0] d,
                                                   input logic [MASK_W-1:0] m,
                                                   input logic [POS_W-1:0] p);
        logic [DIV_W:0] len;
        len = {1'b0, d} + (DIV_W+1)'(m[p]); // [RULE13] [RULE12]
        if (len == '0) begin
            len = (DIV_W+1)'(1);
        end
        return len;
    endfunction

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (!enable) begin
            next_st.running = 1'b0;
        end else if (char_start) begin
            // settings are latched only here, so a live character keeps its timing
            next_st.running = 1'b1; // [RULE14]
            next_st.pos = '0;
            next_st.cnt = '0;
            next_st.div = divisor; // [RULE1]
            next_st.mask = mask;
        end else if (st.running && ref_tick) begin // [RULE2]
            if ((DIV_W+1)'(st.cnt + 1'b1) >= fbg_bit_len(st.div, st.mask, st.pos)) begin
                next_st.cnt = '0;
                next_st.tick = 1'b1;
                next_st.pos = POS_W'(st.pos + 1'b1);
            end else begin
                next_st.cnt = (DIV_W+1)'(st.cnt + 1'b1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bit_tick = st.tick;
    assign running  = st.running;
    assign bit_pos  = st.pos;
endmodule

// >>> hw/fbg_top.sv
`timescale 1ns/10ps
// Overview of operation
// (RULE1) 19-bit divisor, 16-bit masks set bit rate
// (RULE2) bit timing derived from 48 MHz reference
// (RULE3) software writes divisor as truncated 48M/baud
// (RULE4) divisor split over three byte registers
// (RULE5) software keeps top divisor bits zero
// (RULE6) software computes 5-bit fractional index
// (RULE7) software picks transmit mask from table
// (RULE8) receive mask uses same index
// (RULE9) receive mask column by divisor parity
// (RULE10) common rates use precomputed settings
// (RULE11) divisor and masks read back written value
// (RULE12) divisor 4, zero masks gives 12M
// (RULE13) mask bit set adds one cycle
// (RULE14) new settings apply at next character
module fbg_top #(
    parameter int DIV_W  = fbg_pkg::DIV_W,
    parameter int MASK_W = fbg_pkg::MASK_W,
    parameter int ADDR_W = fbg_pkg::ADDR_W,
    parameter int DATA_W = fbg_pkg::DATA_W,
    parameter int POS_W  = fbg_pkg::POS_W
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [DATA_W-1:0]      reg_rdata,
    // transmitter side
    input  wire logic              tx_enable,
    input  wire logic              tx_char_start,
    output logic                   tx_bit_tick,
    // receiver side
    input  wire logic              rx_enable,
    input  wire logic              rx_char_start,
    output logic                   rx_bit_tick,
    // reference enable
    output logic                   ref_tick
);
    typedef struct packed {
        logic [DATA_W-1:0]         rdata;
        logic [DIV_W-1:0]          div;
        logic [MASK_W-1:0]         txm;
        logic [MASK_W-1:0]         rxm;
        logic [fbg_pkg::ACC_W-1:0] acc;
        logic                      ref_tick;
        logic                      tx_pend;
        logic                      rx_pend;
    } fbg_top_state_t;

    fbg_top_state_t st;
    fbg_top_state_t next_st;

    logic             tx_run;
    logic             rx_run;
    logic [POS_W-1:0] tx_pos;
    logic [POS_W-1:0] rx_pos;

    function automatic logic [DATA_W-1:0] fbg_read(input logic [ADDR_W-1:0] a,
                                                   input fbg_top_state_t s,
                                                   input logic [7:0] status);
        logic [DATA_W-1:0] d;
        d = '0;
        unique case (a)
            ADDR_W'(fbg_pkg::OFS_DIV_LOW):  d = s.div[7:0]; // [RULE11]
            ADDR_W'(fbg_pkg::OFS_DIV_MID):  d = s.div[15:8];
            // reserved high bits are not stored and read as zero
            ADDR_W'(fbg_pkg::OFS_DIV_HIGH): d = {5'h00, s.div[18:16]};
            ADDR_W'(fbg_pkg::OFS_TXM_LOW):  d = s.txm[7:0];
            ADDR_W'(fbg_pkg::OFS_TXM_HIGH): d = s.txm[15:8];
            ADDR_W'(fbg_pkg::OFS_RXM_LOW):  d = s.rxm[7:0];
            ADDR_W'(fbg_pkg::OFS_RXM_HIGH): d = s.rxm[15:8];
            ADDR_W'(fbg_pkg::OFS_STATUS):   d = status;
            default:                        d = '0;
        endcase
        return d;
    endfunction

    logic [fbg_pkg::ACC_W-1:0] acc_sum;
    logic [7:0]                status;

    always_comb begin
        next_st = st;
        next_st.ref_tick = 1'b0;
        // 48/250 exactly: the reference enable has no long-term drift
        acc_sum = fbg_pkg::ACC_W'(st.acc + fbg_pkg::ACC_W'(fbg_pkg::REF_STEP));
        if (acc_sum >= fbg_pkg::ACC_W'(fbg_pkg::REF_MOD)) begin
            next_st.acc = fbg_pkg::ACC_W'(acc_sum - fbg_pkg::ACC_W'(fbg_pkg::REF_MOD));
            next_st.ref_tick = 1'b1; // [RULE2]
        end else begin
            next_st.acc = acc_sum;
        end

        status = '0;
        status[fbg_pkg::ST_TX_RUN] = tx_run;
        status[fbg_pkg::ST_RX_RUN] = rx_run;
        status[fbg_pkg::ST_TX_PEND] = st.tx_pend;
        status[fbg_pkg::ST_RX_PEND] = st.rx_pend;
        status[fbg_pkg::ST_POS_LSB +: POS_W] = tx_pos;

        next_st.rdata = '0;
        if (reg_rd) begin
            next_st.rdata = fbg_read(reg_addr, st, status);
        end

        // a start clears pending; a write in the same cycle sets it again
        if (tx_enable && tx_char_start) begin
            next_st.tx_pend = 1'b0;
        end
        if (rx_enable && rx_char_start) begin
            next_st.rx_pend = 1'b0;
        end

        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_W'(fbg_pkg::OFS_DIV_LOW): begin
                    next_st.div[7:0] = reg_wdata; // [RULE4]
                    next_st.tx_pend = 1'b1;
                    next_st.rx_pend = 1'b1;
                end
                ADDR_W'(fbg_pkg::OFS_DIV_MID): begin
                    next_st.div[15:8] = reg_wdata; // [RULE4]
                    next_st.tx_pend = 1'b1;
                    next_st.rx_pend = 1'b1;
                end
                ADDR_W'(fbg_pkg::OFS_DIV_HIGH): begin
                    next_st.div[18:16] = reg_wdata[fbg_pkg::DIV_HI_W-1:0]; // [RULE4]
                    next_st.tx_pend = 1'b1;
                    next_st.rx_pend = 1'b1;
                end
                ADDR_W'(fbg_pkg::OFS_TXM_LOW): begin
                    next_st.txm[7:0] = reg_wdata; // [RULE1]
                    next_st.tx_pend = 1'b1;
                end
                ADDR_W'(fbg_pkg::OFS_TXM_HIGH): begin
                    next_st.txm[15:8] = reg_wdata;
                    next_st.tx_pend = 1'b1;
                end
                ADDR_W'(fbg_pkg::OFS_RXM_LOW): begin
                    next_st.rxm[7:0] = reg_wdata;
                    next_st.rx_pend = 1'b1;
                end
                ADDR_W'(fbg_pkg::OFS_RXM_HIGH): begin
                    next_st.rxm[15:8] = reg_wdata;
                    next_st.rx_pend = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st <= '0;
            st.div <= fbg_pkg::DIV_RESET;
            st.txm <= fbg_pkg::MASK_RESET;
            st.rxm <= fbg_pkg::MASK_RESET;
        end else begin
            st <= next_st;
        end
    end

    fbg_bit_timer #(
        .DIV_W  (DIV_W),
        .MASK_W (MASK_W),
        .POS_W  (POS_W)
    ) u_tx_timer (
        .clk        (clk),
        .resetn     (resetn),
        .ref_tick   (st.ref_tick),
        .enable     (tx_enable),
        .char_start (tx_char_start),
        .divisor    (st.div),
        .mask       (st.txm),
        .bit_tick   (tx_bit_tick),
        .running    (tx_run),
        .bit_pos    (tx_pos)
    );

    fbg_bit_timer #(
        .DIV_W  (DIV_W),
        .MASK_W (MASK_W),
        .POS_W  (POS_W)
    ) u_rx_timer (
        .clk        (clk),
        .resetn     (resetn),
        .ref_tick   (st.ref_tick),
        .enable     (rx_enable),
        .char_start (rx_char_start),
        .divisor    (st.div),
        .mask       (st.rxm),
        .bit_tick   (rx_bit_tick),
        .running    (rx_run),
        .bit_pos    (rx_pos)
    );

    assign reg_rdata = st.rdata;
    assign ref_tick  = st.ref_tick;
endmodule

// >>> tb/fbg_props.sv
`timescale 1ns/10ps
module fbg_props (
    // clock and reset
    input wire logic       clk,
    input wire logic       resetn,
    // register port
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // timers
    input wire logic       tx_enable,
    input wire logic       tx_bit_tick,
    input wire logic       rx_enable,
    input wire logic       rx_bit_tick,
    input wire logic       ref_tick
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    // 48 of 250 clocks: spacing is always 5 or 6
    sequence s_ref_quiet;
        !ref_tick [*4];
    endsequence

    a_ref_gap: assert property (ref_tick |=> s_ref_quiet ##[1:2] ref_tick)
        else $error("reference tick spacing wrong");
    a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    a_tx_single: assert property (tx_bit_tick |=> !tx_bit_tick)
        else $error("transmit tick too long");
    a_rx_single: assert property (rx_bit_tick |=> !rx_bit_tick)
        else $error("receive tick too long");
    a_tx_after_ref: assert property (tx_bit_tick |-> $past(ref_tick))
        else $error("transmit tick without reference");
    a_rx_after_ref: assert property (rx_bit_tick |-> $past(ref_tick))
        else $error("receive tick without reference");
    a_tx_stopped: assert property (!tx_enable [*3] |-> !tx_bit_tick)
        else $error("transmit tick while disabled");
    a_rx_stopped: assert property (!rx_enable [*3] |-> !rx_bit_tick)
        else $error("receive tick while disabled");
endmodule

// >>> tb/fbg_line_model.sv
`timescale 1ns/10ps
module fbg_line_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // line activity
    input  wire logic send,
    output logic      rx_char_start
);
    // start bit edge seen one clock after the far end sends
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rx_char_start <= 1'b0;
        end else begin
            rx_char_start <= send;
        end
    end
endmodule

// >>> tb/test_fbg_top.sv
`timescale 1ns/10ps
module test_fbg_top;
    logic        clk;
    logic        resetn;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        tx_enable;
    logic        tx_char_start;
    logic        tx_bit_tick;
    logic        rx_enable;
    logic        rx_send;
    logic        rx_char_start;
    logic        rx_bit_tick;
    logic        ref_tick;
    int          n_mismatch;
    int          total_checks;
    logic [50:0] rows [6];

    fbg_top i_fbg_top (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tx_enable(tx_enable), .tx_char_start(tx_char_start), .tx_bit_tick(tx_bit_tick),
        .rx_enable(rx_enable), .rx_char_start(rx_char_start), .rx_bit_tick(rx_bit_tick),
        .ref_tick(ref_tick));
    fbg_line_model i_fbg_line_model (.clk(clk), .resetn(resetn), .send(rx_send),
        .rx_char_start(rx_char_start));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task chk(input string nm, input logic [18:0] s, input logic [18:0] e);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    task final_report;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk("reg_rdata", 19'(reg_rdata), 19'(e));
    endtask

    // w = {divisor, transmit mask, receive mask}
    task prog(input logic [50:0] w);
        logic [7:0] b [7];
        b = '{w[39:32], w[47:40], {5'h00, w[50:48]}, w[23:16], w[31:24], w[7:0], w[15:8]};
        for (int i = 0; i < 7; i++)
            wr(fbg_pkg::OFS_DIV_LOW + 8'(i), b[i]);
        for (int i = 0; i < 7; i++)
            rd(fbg_pkg::OFS_DIV_LOW + 8'(i), b[i]);
    endtask

    // bit length in reference ticks is divisor plus that bit's mask bit
    task run_char(input logic [50:0] w);
        int ct, cr, bt, br, lim;
        {ct, cr, bt, br, lim} = '0;
        @(posedge clk);
        rx_send <= 1'b1;
        @(posedge clk);
        rx_send <= 1'b0;
        tx_char_start <= 1'b1;
        @(posedge clk);
        tx_char_start <= 1'b0;
        while ((bt < 16 || br < 16) && lim < 4000) begin
            @(negedge clk);
            lim++;
            if (tx_bit_tick === 1'b1 && bt < 16) begin
                chk("tx bit", 19'(ct), w[50:32] + 19'(w[16+bt]));
                bt++;
                ct = 0;
            end
            if (rx_bit_tick === 1'b1 && br < 16) begin
                chk("rx bit", 19'(cr), w[50:32] + 19'(w[br]));
                br++;
                cr = 0;
            end
            if (ref_tick === 1'b1) begin
                ct++;
                cr++;
            end
        end
        if (lim >= 4000) begin
            chk("tick wait", 19'h00001, 19'h00000);
            final_report();
        end
    endtask

    initial begin
        {resetn, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {tx_enable, tx_char_start, rx_enable, rx_send} = '0;
        n_mismatch = 0;
        total_checks = 0;
        rows[0] = {19'd4, 16'h0000, 16'h0000};
        rows[1] = {19'd7, 16'h0b6d, 16'h0db6};
        rows[2] = {19'd11, 16'h0122, 16'h0224};
        rows[3] = {19'd13, 16'h076d, 16'h0bb6};
        rows[4] = {19'd5, 16'h0fff, 16'h0ffd};
        rows[5] = {19'd4, 16'h0fff, 16'h0ffe};
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 7; i++)
            rd(fbg_pkg::OFS_DIV_LOW + 8'(i), 8'h00);
        @(posedge clk);
        tx_enable <= 1'b1;
        rx_enable <= 1'b1;
        foreach (rows[i]) begin
            prog(rows[i]);
            run_char(rows[i]);
        end
        $display("table done");
        wr(fbg_pkg::OFS_DIV_HIGH, 8'hff);
        rd(fbg_pkg::OFS_DIV_HIGH, 8'h07);
        wr(8'h30, 8'h5a);
        rd(8'h30, 8'h00);
        $display("reserved done");
        // divisor rewritten mid character: old timing holds until restart
        prog(rows[0]);
        fork
            run_char(rows[0]);
            begin
                repeat (60) @(posedge clk);
                wr(fbg_pkg::OFS_DIV_LOW, 8'h01);
            end
        join
        run_char({19'd1, 32'h00000000});
        $display("update done");
        @(posedge clk);
        tx_enable <= 1'b0;
        rx_enable <= 1'b0;
        tx_char_start <= 1'b1;
        @(posedge clk);
        tx_char_start <= 1'b0;
        // a start with both enables low is refused: no tick may follow
        repeat (40) begin
            @(negedge clk);
            chk("stopped ticks", 19'({tx_bit_tick, rx_bit_tick}), 19'h00000);
        end
        @(posedge clk);
        resetn <= 1'b0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        rd(fbg_pkg::OFS_DIV_LOW, 8'h00);
        rd(fbg_pkg::OFS_STATUS, 8'h00);
        // a transmit mask write flags only the transmit side as pending
        wr(fbg_pkg::OFS_TXM_LOW, 8'h6d);
        rd(fbg_pkg::OFS_STATUS, 8'h04);
        $display("stop and reset done");
        final_report();
    end
endmodule

bind fbg_top fbg_props i_fbg_props (.clk(clk), .resetn(resetn), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_enable(tx_enable), .tx_bit_tick(tx_bit_tick),
    .rx_enable(rx_enable), .rx_bit_tick(rx_bit_tick), .ref_tick(ref_tick));
